//--- rtl/gpd_pkg.sv
// gpd_pkg: register map, field positions and reset values of the gpio port block
// assumes a 32-bit AHB-Lite bus with one aligned word per register
package gpd_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_PORT_A_DATA      = 8'h00;
    localparam logic [7:0] OFS_PORT_B_DATA      = 8'h04;
    localparam logic [7:0] OFS_PORT_A_DIRECTION = 8'h08;
    localparam logic [7:0] OFS_PORT_B_DIRECTION = 8'h0C;
    localparam logic [7:0] OFS_PORT_A_PULLDOWN  = 8'h10;
    localparam logic [7:0] OFS_PORT_B_PULLDOWN  = 8'h14;
    localparam logic [7:0] OFS_OPTION           = 8'h18;

    // port widths
    localparam int PA_W = 6;
    localparam int PB_W = 8;
    localparam int PC_W = 8;

    // port_a_pulldown_control field positions
    localparam int PDA_INHIBIT_LSB = 0;
    localparam int PDA_PC_LOWER    = 6;
    localparam int PDA_PC_UPPER    = 7;

    // option register field positions
    localparam int OPT_GLOBAL_PD_DISABLE = 0;
    localparam int OPT_PORT_IRQ          = 1;
    localparam int OPT_IRQ_LEVEL         = 2;

    // reset values
    localparam logic [5:0] RST_PA_DIR = 6'h00;
    localparam logic [7:0] RST_PB_DIR = 8'h00;
    localparam logic [5:0] RST_PA_INH = 6'h00;
    localparam logic [7:0] RST_PB_INH = 8'h00;
    localparam logic       RST_PC_INH = 1'b0;
    localparam logic       RST_OPTION = 1'b0;

    // ahb codes
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam logic [1:0] HTRANS_SEQ    = 2'b11;
    localparam logic       HRESP_OKAY    = 1'b0;

    // number of port a pins that double as interrupt inputs
    localparam int IRQ_PINS = 4;

endpackage

//--- rtl/gpd_top.sv
// gpd_top: port a (6 pins) and port b (8 pins) gpio with pulldown control,
// port c group pulldowns and port a interrupt inputs, as an AHB-Lite slave.
// assumes pins are asynchronous to hclk and pad logic resolves oe/out/pulldown.
// Contract
// - port A direction one drives pin and turns pulldown off; zero is input.
// - upper two port A direction bits read as zero.
// - reset clears port A direction, all port A pins inputs.
// - port A inhibit one kills pulldown; zero enables it only for inputs.
// - global pulldown disable forces every pulldown off.
// - two port A pulldown bits inhibit upper and lower port C groups.
// - reset clears port A pulldown register, port C group bits included.
// - option makes port A pins 0-3 interrupt inputs, high or rising.
// - option state selects edge only or edge plus level sensing.
// - data read returns latch for outputs, sampled pin for inputs.
// - data writes always update the output latch.
// - direction registers always readable and writable.
// - reset leaves port B data latch unchanged.
// - port B direction one drives pin, kills pulldown; reset clears all.
// - port B pulldown register write only, one inhibit bit per pin.
// - port B inhibit one kills pulldown; reset enables all.
// - port B pins 0-3 pass input level on; pins 4-7 overridable.
// - port A data readable and writable, upper bits zero, kept in reset.
`timescale 1ns/100ps

module gpd_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [5:0]  pa_in,
    output logic      [5:0]  pa_out,
    output logic      [5:0]  pa_oe,
    output logic      [5:0]  pa_pulldown_en,
    input  wire logic [7:0]  pb_in,
    output logic      [7:0]  pb_out,
    output logic      [7:0]  pb_oe,
    output logic      [7:0]  pb_pulldown_en,
    input  wire logic [3:0]  pb_alt_oe,
    input  wire logic [3:0]  pb_alt_out,
    output logic      [3:0]  pb_shared_in,
    input  wire logic [7:0]  port_c_direction,
    output logic      [7:0]  pc_pulldown_en,
    output logic             port_irq_request
);

    // register map, one aligned word per register, data in the low bits:
    //   0x00 port_a_data      six implemented bits, upper bits read zero
    //   0x04 port_b_data      eight bits
    //   0x08 port_a_direction six bits, upper two read zero
    //   0x0c port_b_direction eight bits
    //   0x10 port_a_pulldown_control, write only, reads zero
    //        bits 5:0 port A inhibit, bit 6 lower port C group,
    //        bit 7 upper port C group
    //   0x14 port_b_pulldown_control, write only, reads zero
    //   0x18 option word: bit 0 global pulldown disable,
    //        bit 1 port interrupt enable, bit 2 level sensing
    //
    // bus timing:
    //   the slave never stalls, hreadyout is high from reset onwards
    //   an address phase taken at edge k is answered at edge k+1
    //   write data is applied at the edge that closes the data phase
    //   read data is registered at the edge that takes the address
    //   a read right after a write to the same word sees the new value,
    //   because the read mux looks at the next-state copy
    //   unmapped addresses are accepted, writes dropped, reads zero
    //
    // pin timing:
    //   each pin passes three flops before it is trusted
    //   the filtered value moves only when stages two and three agree,
    //   so a one-cycle glitch never reaches a read or the interrupt
    //   a stable change is visible to a data read five edges later
    //   the shared port B input lags the pin by five edges
    //   the interrupt request lags a rising pin by five edges
    //
    // pulldown control:
    //   a pulldown is on only for an input pin whose inhibit bit is clear
    //   and while the global disable is clear
    //   a driven pin never has its pulldown on, whatever the inhibit holds
    //   port C direction comes from outside on this clock, so the group
    //   pulldowns follow it one edge later
    //
    // upper port B pins:
    //   other modules may take a pin over through pb_alt_oe/pb_alt_out;
    //   the pulldown then turns off as for any driven pin
    //   a data read of such a pin still follows port_b_direction, so
    //   software sees its own latch or the filtered pin level
    //
    // interrupt inputs:
    //   only the four low port A pins take part
    //   edge mode gives a one-cycle request per filtered rising edge
    //   level mode also holds the request while any of those pins is high
    //   with the option clear the request stays low
    //
    // reset:
    //   directions, inhibits and options clear, so every pin is an input
    //   with its pulldown on after the first edge past release
    //   the data latches sit outside the reset on purpose; they keep their
    //   contents and power up unknown, which is harmless while all pins
    //   are inputs because the pin value is gated by direction
    //
    // limitations:
    //   hsize is ignored, only whole-word transfers are meaningful
    //   byte writes would update the whole register
    //   the error response is never used

    // whole state of the block, registered as one bank
    typedef struct packed {
        logic [5:0]  pa_s1;
        logic [5:0]  pa_s2;
        logic [5:0]  pa_s3;
        logic [5:0]  pa_filt;
        logic [7:0]  pb_s1;
        logic [7:0]  pb_s2;
        logic [7:0]  pb_s3;
        logic [7:0]  pb_filt;
        logic [3:0]  irq_prev;
        logic [5:0]  pa_data;
        logic [7:0]  pb_data;
        logic [5:0]  pa_dir;
        logic [7:0]  pb_dir;
        logic [5:0]  pa_inh;
        logic        pc_hi_inh;
        logic        pc_lo_inh;
        logic [7:0]  pb_inh;
        logic        gpd;
        logic        port_interrupt_option;
        logic        irq_lvl;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] hrdata;
        logic        hready;
        logic        hresp;
        logic [5:0]  pa_out;
        logic [5:0]  pa_oe;
        logic [5:0]  pa_pd;
        logic [7:0]  pb_out;
        logic [7:0]  pb_oe;
        logic [7:0]  pb_pd;
        logic [7:0]  pc_pd;
        logic [3:0]  pb_share;
        logic        irq;
    } gpd_state_t;

    gpd_state_t r;
    gpd_state_t n;

    logic        addr_ok;
    logic        mapped;
    logic [7:0]  rd_addr;
    logic [31:0] rd_val;
    logic [3:0]  rise;
    logic [7:0]  pb_oe_eff;

    // bus address phase qualifier
    assign addr_ok = hsel && hready && (htrans == gpd_pkg::HTRANS_NONSEQ
                                        || htrans == gpd_pkg::HTRANS_SEQ);
    assign mapped  = (haddr[31:8] == 24'h0000_00);
    assign rd_addr = haddr[7:0];

    always_comb begin
        n = r;
        rd_val = 32'h0000_0000;
        // three-stage synchronisers; a change counts once stages two and three agree
        n.pa_s1 = pa_in;
        n.pa_s2 = r.pa_s1;
        n.pa_s3 = r.pa_s2;
        if (r.pa_s2 == r.pa_s3) begin
            n.pa_filt = r.pa_s3;
        end
        n.pb_s1 = pb_in;
        n.pb_s2 = r.pb_s1;
        n.pb_s3 = r.pb_s2;
        if (r.pb_s2 == r.pb_s3) begin
            n.pb_filt = r.pb_s3;
        end

        // data phase of a pending write; zero wait so it ends this edge
        n.wr_pend = 1'b0;
        if (r.wr_pend) begin
            unique case (r.wr_addr)
                gpd_pkg::OFS_PORT_A_DATA: begin
                    n.pa_data = hwdata[5:0];
                end
                gpd_pkg::OFS_PORT_B_DATA: begin
                    n.pb_data = hwdata[7:0];
                end
                gpd_pkg::OFS_PORT_A_DIRECTION: begin
                    n.pa_dir = hwdata[5:0];
                end
                gpd_pkg::OFS_PORT_B_DIRECTION: begin
                    n.pb_dir = hwdata[7:0];
                end
                gpd_pkg::OFS_PORT_A_PULLDOWN: begin
                    n.pa_inh    = hwdata[gpd_pkg::PDA_INHIBIT_LSB +: 6];
                    n.pc_lo_inh = hwdata[gpd_pkg::PDA_PC_LOWER];
                    n.pc_hi_inh = hwdata[gpd_pkg::PDA_PC_UPPER];
                end
                gpd_pkg::OFS_PORT_B_PULLDOWN: begin
                    n.pb_inh = hwdata[7:0];
                end
                gpd_pkg::OFS_OPTION: begin
                    n.gpd     = hwdata[gpd_pkg::OPT_GLOBAL_PD_DISABLE];
                    n.port_interrupt_option    = hwdata[gpd_pkg::OPT_PORT_IRQ];
                    n.irq_lvl = hwdata[gpd_pkg::OPT_IRQ_LEVEL];
                end
                default: begin
                    // unmapped writes are dropped, answer stays okay
                end
            endcase
        end

        // address phase; read value built from post-write state
        if (addr_ok) begin
            n.wr_pend = hwrite && mapped;
            n.wr_addr = rd_addr;
        end
        if (addr_ok && !hwrite && mapped) begin
            unique case (rd_addr)
                gpd_pkg::OFS_PORT_A_DATA: begin
                    // latch for outputs, pin for inputs
                    rd_val[5:0] = (n.pa_dir & n.pa_data) | (~n.pa_dir & r.pa_filt);
                end
                gpd_pkg::OFS_PORT_B_DATA: begin
                    // latch for outputs, pin for inputs
                    rd_val[7:0] = (n.pb_dir & n.pb_data) | (~n.pb_dir & r.pb_filt);
                end
                gpd_pkg::OFS_PORT_A_DIRECTION: begin
                    rd_val[5:0] = n.pa_dir;
                end
                gpd_pkg::OFS_PORT_B_DIRECTION: begin
                    rd_val[7:0] = n.pb_dir;
                end
                gpd_pkg::OFS_OPTION: begin
                    rd_val[gpd_pkg::OPT_GLOBAL_PD_DISABLE] = n.gpd;
                    rd_val[gpd_pkg::OPT_PORT_IRQ]          = n.port_interrupt_option;
                    rd_val[gpd_pkg::OPT_IRQ_LEVEL]         = n.irq_lvl;
                end
                default: begin
                    // write-only pulldown registers and holes read zero
                    rd_val = 32'h0000_0000;
                end
            endcase
        end
        n.hrdata = rd_val;
        n.hready = 1'b1;
        n.hresp  = gpd_pkg::HRESP_OKAY;

        // pin controls from next register state so a write lands this edge
        // same edge as write
        n.pa_oe  = n.pa_dir;
        n.pa_out = n.pa_dir & n.pa_data;
        n.pa_pd  = ~n.pa_dir & ~n.pa_inh & {6{~n.gpd}};

        // upper port b pins overridden by other modules
        pb_oe_eff = n.pb_dir | {pb_alt_oe, 4'h0};
        n.pb_oe  = pb_oe_eff;
        n.pb_out = (n.pb_dir & n.pb_data) | {pb_alt_oe & pb_alt_out, 4'h0};
        n.pb_pd  = ~pb_oe_eff & ~n.pb_inh & {8{~n.gpd}};

        n.pc_pd = ~port_c_direction & {{4{~n.pc_hi_inh}}, {4{~n.pc_lo_inh}}}
                  & {8{~n.gpd}};

        n.pb_share = r.pb_filt[3:0];

        n.irq_prev = r.pa_filt[3:0];
        rise       = r.pa_filt[3:0] & ~r.irq_prev;
        // edge only or edge plus level
        n.irq = r.port_interrupt_option && ((|rise) || (r.irq_lvl && (|r.pa_filt[3:0])));
    end

    // one register bank; data latches deliberately outside the reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r.pa_s1     <= 6'h00;
            r.pa_s2     <= 6'h00;
            r.pa_s3     <= 6'h00;
            r.pa_filt   <= 6'h00;
            r.pb_s1     <= 8'h00;
            r.pb_s2     <= 8'h00;
            r.pb_s3     <= 8'h00;
            r.pb_filt   <= 8'h00;
            r.irq_prev  <= 4'h0;
            r.pa_dir    <= gpd_pkg::RST_PA_DIR;
            r.pb_dir    <= gpd_pkg::RST_PB_DIR;
            r.pa_inh    <= gpd_pkg::RST_PA_INH;
            r.pc_hi_inh <= gpd_pkg::RST_PC_INH;
            r.pc_lo_inh <= gpd_pkg::RST_PC_INH;
            r.pb_inh    <= gpd_pkg::RST_PB_INH;
            r.gpd       <= gpd_pkg::RST_OPTION;
            r.port_interrupt_option      <= gpd_pkg::RST_OPTION;
            r.irq_lvl   <= gpd_pkg::RST_OPTION;
            r.wr_pend   <= 1'b0;
            r.wr_addr   <= 8'h00;
            r.hrdata    <= 32'h0000_0000;
            r.hready    <= 1'b1;
            r.hresp     <= 1'b0;
            r.pa_out    <= 6'h00;
            r.pa_oe     <= 6'h00;
            r.pa_pd     <= 6'h00;
            r.pb_out    <= 8'h00;
            r.pb_oe     <= 8'h00;
            r.pb_pd     <= 8'h00;
            r.pc_pd     <= 8'h00;
            r.pb_share  <= 4'h0;
            r.irq       <= 1'b0;
        end else begin
            r <= n;
        end
    end

    // every output straight from the register bank
    assign hrdata           = r.hrdata;
    assign hreadyout        = r.hready;
    assign hresp            = r.hresp;
    assign pa_out           = r.pa_out;
    assign pa_oe            = r.pa_oe;
    assign pa_pulldown_en   = r.pa_pd;
    assign pb_out           = r.pb_out;
    assign pb_oe            = r.pb_oe;
    assign pb_pulldown_en   = r.pb_pd;
    assign pb_shared_in     = r.pb_share;
    assign pc_pulldown_en   = r.pc_pd;
    assign port_irq_request = r.irq;

endmodule

//--- dv/gpd_checker.sv
// gpd_checker: port-level assertions for gpd_top
// assumes one slave, hready fed back from hreadyout
`timescale 1ns/100ps
module gpd_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic [5:0]  pa_in,
    input wire logic [5:0]  pa_out,
    input wire logic [5:0]  pa_oe,
    input wire logic [5:0]  pa_pulldown_en,
    input wire logic [7:0]  pb_in,
    input wire logic [7:0]  pb_oe,
    input wire logic [7:0]  pb_pulldown_en,
    input wire logic [3:0]  pb_shared_in,
    input wire logic [7:0]  port_c_direction,
    input wire logic [7:0]  pc_pulldown_en,
    input wire logic        port_irq_request
);
    logic wr_dp;
    logic up;
    wire  take = hsel & hready & htrans[1];
    wire  rd_take = take & !hwrite;
    wire  rd_dir = rd_take & (haddr[7:0] == gpd_pkg::OFS_PORT_A_DIRECTION);
    // write data phase marker; up stays low for the first edge after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp <= 1'b0;
            up    <= 1'b0;
        end else begin
            wr_dp <= take & hwrite;
            up    <= 1'b1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_pa_oe_pd: assert property (
        (pa_oe & pa_pulldown_en) == 6'h00) else $error("pa pulldown on while driven");
    a_pa_out_gate: assert property (
        (pa_out & ~pa_oe) == 6'h00) else $error("pa output without enable");
    a_pb_oe_pd: assert property (
        (pb_oe[3:0] & pb_pulldown_en[3:0]) == 4'h0) else $error("pb pulldown while driven");
    a_pc_pd_dir: assert property (
        (pc_pulldown_en & $past(port_c_direction)) == 8'h00) else $error("pc pulldown on output");
    a_irq_cause: assert property (
        $rose(port_irq_request) |-> $past(pa_in[3:0], 4) != 4'h0) else $error("irq with no pin");
    a_shared_lag: assert property (
        (pb_in[3:0] == $past(pb_in[3:0]))[*6] |=> pb_shared_in == $past(pb_in[3:0]))
        else $error("shared input lags");
    a_pin_edge: assert property (
        $changed({pa_oe, pa_pulldown_en, pb_pulldown_en}) |-> $past(wr_dp) || !$past(up))
        else $error("pin control moved without write");
    a_rd_idle: assert property (
        !$past(rd_take) |-> hrdata == 32'h0000_0000) else $error("read data without read");
    a_dir_upper: assert property (
        $past(rd_dir) |-> hrdata[7:6] == 2'b00) else $error("direction upper bits set");
    c_irq: cover property ($rose(port_irq_request));
    c_dir_rd: cover property ($past(rd_dir));
    c_oe: cover property ($changed(pa_oe));
endmodule

bind gpd_top gpd_checker u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .pa_in,
    .pa_out, .pa_oe, .pa_pulldown_en, .pb_in, .pb_oe, .pb_pulldown_en,
    .pb_shared_in, .port_c_direction, .pc_pulldown_en, .port_irq_request
);

//--- dv/gpd_pins.sv
// gpd_pins: board side of one port, resolves each pin level
// assumes the bench picks which pins a board source drives
`timescale 1ns/100ps
module gpd_pins #(
    parameter int W = 8
) (
    input  wire logic         hclk,
    input  wire logic [W-1:0] drv_out,
    input  wire logic [W-1:0] drv_oe,
    input  wire logic [W-1:0] pd_en,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    output logic      [W-1:0] pin
);
    logic flt = 1'b0;
    // floating pins wander so a stale level is never trusted
    always @(posedge hclk) begin
        flt <= ~flt;
    end
    // device driver wins, then board source, then pulldown
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = drv_oe[i] ? drv_out[i] : ext_en[i] ? ext_val[i] : pd_en[i] ? 1'b0 : flt;
        end
    end
endmodule

//--- dv/gpd_top_tb.sv
// gpd_top_tb: self-checking bench for the gpio port block
// assumes a single bus slave, so hready comes from hreadyout
`timescale 1ns/100ps
module gpd_top_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0]  htrans = 2'b00;
    logic [5:0]  ea_en = 6'h00;
    logic [5:0]  ea_v = 6'h00;
    logic [7:0]  eb_en = 8'hFF;
    logic [7:0]  eb_v = 8'hA5;
    logic [7:0]  port_c_direction = 8'h3C;
    logic [31:0] hrdata, r;
    logic [5:0]  pa_in, pa_out, pa_oe, pa_pulldown_en;
    logic [7:0]  pb_in, pb_out, pb_oe, pb_pulldown_en, pc_pulldown_en;
    logic [3:0]  pb_shared_in;
    logic        hreadyout, hresp, port_irq_request;
    int          fail_count = 0;
    int          total_checks = 0;
    // rows: offset, written word, expected read-back
    logic [71:0] rows [4] = '{{8'h08, 32'hFFFF_FFFF, 32'h0000_003F},
        {8'h0C, 32'h0000_00A5, 32'h0000_00A5}, {8'h14, 32'h0000_005A, 32'h0000_0000},
        {8'h40, 32'h0000_0012, 32'h0000_0000}};
    always #2.5 hclk = ~hclk;
    gpd_top dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
        .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .pa_in, .pa_out, .pa_oe, .pa_pulldown_en, .pb_in, .pb_out, .pb_oe,
        .pb_pulldown_en, .pb_alt_oe(4'h0), .pb_alt_out(4'h0), .pb_shared_in,
        .port_c_direction, .pc_pulldown_en, .port_irq_request
    );
    gpd_pins #(.W(6)) pa_pins (.hclk, .drv_out(pa_out), .drv_oe(pa_oe),
        .pd_en(pa_pulldown_en), .ext_en(ea_en), .ext_val(ea_v), .pin(pa_in));
    gpd_pins #(.W(8)) pb_pins (.hclk, .drv_out(pb_out), .drv_oe(pb_oe),
        .pd_en(pb_pulldown_en), .ext_en(eb_en), .ext_val(eb_v), .pin(pb_in));
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait for hreadyout; a stuck bus ends the run
    task automatic wait_rdy(input int lim);
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < lim);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            final_report();
        end
    endtask
    // single word transfer; at the closing edge htrans is idle and only hwdata is driven
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= gpd_pkg::HTRANS_NONSEQ;
        wait_rdy(20);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy(20);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(a, 1'b0, 32'h0000_0000);
        chk(nm, e, r);
        chk("hresp", 32'h0000_0000, hresp);
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge hclk);
    endtask
    task automatic wait_irq;
        for (int n = 0; n < 12 && port_irq_request !== 1'b1; n++) @(posedge hclk);
        chk("irq_up", 32'h0000_0001, port_irq_request);
    endtask
    // main sequence: reset state, table, then hand-written cases
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        wt(6);
        chk("pa_pd", 32'h0000_003F, pa_pulldown_en);
        chk("pb_pd", 32'h0000_00FF, pb_pulldown_en);
        chk("pc_pd", 32'h0000_00C3, pc_pulldown_en);
        chk("shared", 32'h0000_0005, pb_shared_in);
        rd(8'h08, 32'h0000_0000, "dir_a");
        rd(8'h0C, 32'h0000_0000, "dir_b");
        for (int i = 0; i < 4; i++) begin
            wr(rows[i][71:64], rows[i][63:32]);
            rd(rows[i][71:64], rows[i][31:0], "row");
        end
        wr(8'h08, 32'h0000_0000);
        wr(8'h0C, 32'h0000_0000);
        wr(8'h00, 32'h0000_002A);
        ea_en <= 6'h3F;
        ea_v <= 6'h15;
        wt(4);
        chk("pa_out", 32'h0000_0000, pa_out);
        rd(8'h00, 32'h0000_0015, "pa_pin");
        wr(8'h08, 32'h0000_003F);
        wt(1);
        chk("pa_out", 32'h0000_002A, pa_out);
        rd(8'h00, 32'h0000_002A, "pa_latch");
        wr(8'h04, 32'h0000_00C3);
        hresetn <= 1'b0;
        wt(3);
        hresetn <= 1'b1;
        wt(2);
        wr(8'h08, 32'h0000_003F);
        wr(8'h0C, 32'h0000_00FF);
        wt(1);
        chk("pa_keep", 32'h0000_002A, pa_out);
        chk("pb_keep", 32'h0000_00C3, pb_out);
        wr(8'h08, 32'h0000_000F);
        wr(8'h0C, 32'h0000_0000);
        wr(8'h10, 32'h0000_0050);
        wr(8'h14, 32'h0000_0081);
        wt(1);
        chk("pa_pd", 32'h0000_0020, pa_pulldown_en);
        chk("pc_pd", 32'h0000_00C0, pc_pulldown_en);
        chk("pb_pd", 32'h0000_007E, pb_pulldown_en);
        wr(8'h18, 32'h0000_0001);
        wt(1);
        chk("pd_all", 32'h0000_0000, {pa_pulldown_en, pb_pulldown_en, pc_pulldown_en});
        wr(8'h18, 32'h0000_0000);
        wr(8'h08, 32'h0000_0000);
        ea_v <= 6'h00;
        wt(6);
        ea_v <= 6'h01;
        wt(8);
        chk("irq_off", 32'h0000_0000, port_irq_request);
        ea_v <= 6'h00;
        wr(8'h18, 32'h0000_0002);
        wt(6);
        ea_v <= 6'h01;
        wait_irq();
        wt(1);
        chk("irq_pulse", 32'h0000_0000, port_irq_request);
        wr(8'h18, 32'h0000_0006);
        wt(3);
        chk("irq_level", 32'h0000_0001, port_irq_request);
        final_report();
    end
endmodule
